// >>> shared/oled_cmd_pkg.sv
/*
 * constants for the command decoder: command codes, reset values, counts.
 * assumes one clock domain and byte-wide host transfers.
 */
package oled_cmd_pkg;
    localparam logic [7:0] CMD_DESELECT = 8'hdb;
    localparam logic [7:0] CMD_PADCFG = 8'hda;
    localparam logic [7:0] CMD_RMW = 8'he0;
    localparam logic [7:0] CMD_END = 8'hee;
    localparam logic [7:0] CMD_NOP = 8'he3;
    localparam logic [6:0] CMD_DISP_ONOFF = 7'h57;
    localparam logic [3:0] CMD_COL_LOW = 4'h0;
    localparam logic [3:0] CMD_COL_HIGH = 4'h1;
    localparam logic [4:0] CMD_PAGE = 5'h16;
    localparam logic [7:0] COL_RESET = 8'h00;
    localparam logic [7:0] COL_LAST = 8'h83;
    localparam logic [2:0] PAGE_RESET = 3'h0;
    localparam logic [7:0] DESELECT_RESET = 8'h35;
    localparam logic [7:0] PADCFG_RESET = 8'h12;
    localparam int RAM_COLS = 132;
    localparam int RAM_DEPTH = 1056;
    localparam logic [3:0] BUSY_RESET_CYCLES = 4'h8;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DESEL_ARG = 3'b010,
        ST_PAD_ARG = 3'b100
    } argState_t;
endpackage

// >>> verilog/oled_cmd_rmw_status.sv
/*
 * command decoder slice: deselect level, pad config, read-modify-write/end,
 * nop, display ram write/read with column auto-increment, status read.
 * assumes host strobes are single-cycle pulses synchronous to clk.
 */
// Function
// R01: byte after deselect-level command becomes the 8-bit deselect level code.
// R02: in read-modify-write, data reads hold column; data writes still advance it.
// R03: read-modify-write stays on until the end command arrives.
// R04: end command leaves read-modify-write and restores the saved column.
// R05: host always pairs read-modify-write with end.
// R06: data write stores byte at page and column, then column advances.
// R07: status read gives busy on D7, display-off on D6, zero on D2..D0.
// R08: commands arriving while busy are ignored.
// R09: host may skip busy polling if it leaves enough time.
// R10: display-state status bit is high when display is off.
// R11: data read returns display ram byte at current page and column.
// R12: outside read-modify-write, each data read advances column by one.
// R13: host does one dummy read after setting the column.
// R14: no display data readback over the serial interface.
// R15: pad config command takes a data byte; resets to 12h.
// R16: command e3h is a no-operation changing nothing.
`timescale 1ns/1ps
module oled_cmd_rmw_status (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic cmdDataSelect,
    input wire logic serialMode,
    input wire logic [7:0] dataIn,
    output logic [7:0] readData,
    output logic readValid,
    output logic busy,
    output logic [7:0] rowDeselectLevel,
    output logic [7:0] comPadConfig,
    output logic displayOn,
    output logic rmwActive,
    output logic [7:0] columnAddr,
    output logic [2:0] pageAddr
);
    import oled_cmd_pkg::*;

    argState_t state_reg, state_next;
    logic [7:0] col_reg, col_next, saved_reg, saved_next;
    logic [2:0] page_reg, page_next;
    logic [7:0] desel_reg, desel_next, pad_reg, pad_next;
    logic disp_reg, disp_next, rmw_reg, rmw_next;
    logic [3:0] busyCnt_reg, busyCnt_next;
    logic busy_reg, busy_next;
    logic [7:0] rdData_reg, rdData_next, rdBuf_reg, rdBuf_next;
    logic rdValid_reg, rdValid_next;
    logic [7:0] ram [0:RAM_DEPTH-1];
    logic cmdWr, dataWr, dataRd, statRd;
    logic [10:0] ramIdx;
    logic [7:0] colInc;

    ////////////////////////////////////////////////////////////////////
    // decode
    assign cmdWr = wrStrobe & ~cmdDataSelect & ~busy_reg; // R08
    assign dataWr = wrStrobe & cmdDataSelect;
    assign dataRd = rdStrobe & cmdDataSelect & ~serialMode; // R14
    assign statRd = rdStrobe & ~cmdDataSelect;
    assign ramIdx = 11'(page_reg * RAM_COLS) + 11'(col_reg);
    // column wraps past the last segment so a long burst started at or below COL_LAST never leaves the map
    assign colInc = (col_reg == COL_LAST) ? COL_RESET : col_reg + 8'h01;

    ////////////////////////////////////////////////////////////////////
    // command, address and mode state
    always_comb begin
        state_next = state_reg;
        col_next = col_reg;
        saved_next = saved_reg;
        page_next = page_reg;
        desel_next = desel_reg;
        pad_next = pad_reg;
        disp_next = disp_reg;
        rmw_next = rmw_reg;
        if (cmdWr) begin
            unique case (state_reg)
                ST_DESEL_ARG: begin
                    desel_next = dataIn; // R01
                    state_next = ST_IDLE;
                end
                ST_PAD_ARG: begin
                    pad_next = dataIn; // R15
                    state_next = ST_IDLE;
                end
                ST_IDLE: begin
                    if (dataIn == CMD_DESELECT) begin
                        state_next = ST_DESEL_ARG; // R01
                    end else if (dataIn == CMD_PADCFG) begin
                        state_next = ST_PAD_ARG; // R15
                    end else if (dataIn == CMD_RMW) begin
                        rmw_next = 1'b1;
                        // re-entry keeps the first saved column
                        if (!rmw_reg) begin
                            saved_next = col_reg; // R04
                        end
                    end else if (dataIn == CMD_END) begin
                        if (rmw_reg) begin
                            col_next = saved_reg; // R04
                        end
                        rmw_next = 1'b0; // R03 R04
                    end else if (dataIn == CMD_NOP) begin
                        state_next = ST_IDLE; // R16
                    end else if (dataIn[7:1] == CMD_DISP_ONOFF) begin
                        disp_next = dataIn[0];
                    end else if (dataIn[7:3] == CMD_PAGE) begin
                        page_next = dataIn[2:0];
                    end else if (dataIn[7:4] == CMD_COL_LOW) begin
                        col_next = {col_reg[7:4], dataIn[3:0]};
                    end else if (dataIn[7:4] == CMD_COL_HIGH) begin
                        col_next = {dataIn[3:0], col_reg[3:0]};
                    end
                end
                default: state_next = ST_IDLE;
            endcase
        end else if (dataWr) begin
            col_next = colInc; // R02 R06
        end else if (dataRd && !rmw_reg) begin
            col_next = colInc; // R12 R02
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            col_reg <= COL_RESET;
            saved_reg <= COL_RESET;
            page_reg <= PAGE_RESET;
            desel_reg <= DESELECT_RESET;
            pad_reg <= PADCFG_RESET; // R15
            disp_reg <= 1'b0;
            rmw_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            col_reg <= col_next;
            saved_reg <= saved_next;
            page_reg <= page_next;
            desel_reg <= desel_next;
            pad_reg <= pad_next;
            disp_reg <= disp_next;
            rmw_reg <= rmw_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // display ram: no reset, contents undefined until written
    always_ff @(posedge clk) begin
        if (dataWr) begin
            ram[ramIdx] <= dataIn; // R06
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path and busy
    // one-deep read buffer: the first read after an address change is stale
    always_comb begin
        rdData_next = rdData_reg;
        rdBuf_next = rdBuf_reg;
        rdValid_next = 1'b0;
        busyCnt_next = busyCnt_reg;
        if (busyCnt_reg != 4'h0) begin
            busyCnt_next = busyCnt_reg - 4'h1;
        end
        busy_next = (busyCnt_next != 4'h0);
        if (statRd) begin
            rdData_next = {busy_reg, ~disp_reg, 6'h00}; // R07 R10
            rdValid_next = 1'b1;
        end else if (dataRd) begin
            rdData_next = rdBuf_reg; // R11
            rdBuf_next = ram[ramIdx]; // R11
            rdValid_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdData_reg <= 8'h00;
            rdBuf_reg <= 8'h00;
            rdValid_reg <= 1'b0;
            busyCnt_reg <= BUSY_RESET_CYCLES;
            busy_reg <= 1'b1;
        end else begin
            rdData_reg <= rdData_next;
            rdBuf_reg <= rdBuf_next;
            rdValid_reg <= rdValid_next;
            busyCnt_reg <= busyCnt_next;
            busy_reg <= busy_next;
        end
    end

    assign readData = rdData_reg;
    assign readValid = rdValid_reg;
    assign busy = busy_reg;
    assign rowDeselectLevel = desel_reg;
    assign comPadConfig = pad_reg;
    assign displayOn = disp_reg;
    assign rmwActive = rmw_reg;
    assign columnAddr = col_reg;
    assign pageAddr = page_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_desel;
        cmdWr && state_reg == ST_DESEL_ARG |=> desel_reg == $past(dataIn);
    endproperty
    a_desel: assert property (p_desel) else $error("deselect level not taken"); // R01

    property p_rmwRead;
        rmw_reg && dataRd && !wrStrobe |=> $stable(col_reg);
    endproperty
    a_rmwRead: assert property (p_rmwRead) else $error("column moved on rmw read"); // R02

    property p_rmwHold;
        rmw_reg && !(cmdWr && state_reg == ST_IDLE && dataIn == CMD_END) |=> rmw_reg;
    endproperty
    a_rmwHold: assert property (p_rmwHold) else $error("rmw left without end"); // R03

    property p_end;
        cmdWr && state_reg == ST_IDLE && dataIn == CMD_END && rmw_reg
            |=> !rmw_reg && col_reg == $past(saved_reg);
    endproperty
    a_end: assert property (p_end) else $error("end did not restore column"); // R04

    property p_write;
        dataWr && !cmdWr |=> col_reg == $past(colInc)
            ##1 ram[$past(ramIdx, 2)] == $past(dataIn, 2);
    endproperty
    a_write: assert property (p_write) else $error("data write wrong"); // R06

    property p_status;
        statRd |=> readValid && readData[7] == $past(busy_reg) && readData[5:0] == 6'h00
            && readData[6] == !$past(disp_reg);
    endproperty
    a_status: assert property (p_status) else $error("status byte wrong"); // R07 R10

    property p_busy;
        busy_reg && !dataWr && !dataRd |=> $stable(state_reg) && $stable(col_reg)
            && $stable(rmw_reg) && $stable(desel_reg);
    endproperty
    a_busy: assert property (p_busy) else $error("command taken while busy"); // R08

    property p_read;
        dataRd && !rmw_reg && !wrStrobe |=> readValid && col_reg == $past(colInc)
            && readData == $past(rdBuf_reg);
    endproperty
    a_read: assert property (p_read) else $error("data read wrong"); // R11 R12

    property p_serial;
        rdStrobe && cmdDataSelect && serialMode |=> !readValid;
    endproperty
    a_serial: assert property (p_serial) else $error("serial readback"); // R14

    property p_nop;
        cmdWr && state_reg == ST_IDLE && dataIn == CMD_NOP
            |=> $stable(col_reg) && $stable(page_reg) && $stable(rmw_reg) && $stable(disp_reg);
    endproperty
    a_nop: assert property (p_nop) else $error("nop changed state"); // R16

    // pad byte lands only through its own command
    property p_pad;
        cmdWr && state_reg == ST_PAD_ARG |=> pad_reg == $past(dataIn);
    endproperty
    a_pad: assert property (p_pad) else $error("pad config not taken"); // R15

    property p_padHold;
        !(cmdWr && state_reg == ST_PAD_ARG) |=> $stable(pad_reg);
    endproperty
    a_padHold: assert property (p_padHold) else $error("pad config moved"); // R15

    property p_deselHold;
        !(cmdWr && state_reg == ST_DESEL_ARG) |=> $stable(desel_reg);
    endproperty
    a_deselHold: assert property (p_deselHold) else $error("deselect level moved"); // R01

    // a second rmw command must not move the saved column
    property p_rmwEnter;
        cmdWr && state_reg == ST_IDLE && dataIn == CMD_RMW
            |=> rmw_reg && saved_reg == ($past(rmw_reg) ? $past(saved_reg) : $past(col_reg));
    endproperty
    a_rmwEnter: assert property (p_rmwEnter) else $error("rmw entry wrong"); // R02 R04

    property p_wrap;
        dataWr && col_reg == COL_LAST |=> col_reg == COL_RESET;
    endproperty
    a_wrap: assert property (p_wrap) else $error("column did not wrap"); // R06

    property p_dispState;
        cmdWr && state_reg == ST_IDLE && dataIn[7:1] == CMD_DISP_ONOFF
            |=> displayOn == $past(dataIn[0]);
    endproperty
    a_dispState: assert property (p_dispState) else $error("display state wrong"); // R10

    property p_validPulse;
        !statRd && !dataRd |=> !readValid;
    endproperty
    a_validPulse: assert property (p_validPulse) else $error("read valid without read"); // R11

    c_rmwCycle: cover property (rmw_reg && dataWr ##[1:20] !rmw_reg);
    c_deselSet: cover property (cmdWr && state_reg == ST_DESEL_ARG);
    c_readBurst: cover property (dataRd ##1 dataRd);
    c_statusBusy: cover property (statRd && busy_reg);
    c_endRestore: cover property (cmdWr && state_reg == ST_IDLE && dataIn == CMD_END && rmw_reg);
endmodule

// >>> tb/host_model.sv
/*
 * host side model: byte writes, byte reads, serial select, busy wait.
 * assumes the decoder samples strobes on rising clk.
 */
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    input wire logic busy,
    input wire logic readValid,
    input wire logic [7:0] readData,
    output logic wrStrobe,
    output logic rdStrobe,
    output logic cmdDataSelect,
    output logic serialMode,
    output logic [7:0] dataIn
);
    logic [7:0] lastRead;
    logic lastValid;
    initial begin
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        cmdDataSelect = 1'b0;
        serialMode = 1'b0;
        dataIn = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // idle data is inverted so a stale byte never looks fresh
    task automatic wr(input logic cds, input logic [7:0] d);
        @(posedge clk);
        wrStrobe <= 1'b1;
        cmdDataSelect <= cds;
        dataIn <= d;
        @(posedge clk);
        wrStrobe <= 1'b0;
        dataIn <= ~d;
    endtask
    task automatic rd(input logic cds);
        @(posedge clk);
        rdStrobe <= 1'b1;
        cmdDataSelect <= cds;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1;
        lastRead = readData;
        lastValid = readValid;
    endtask
    task automatic setSerial(input logic s);
        @(posedge clk);
        serialMode <= s;
    endtask
    // polling is optional; bounded so a stuck flag cannot hang us
    task automatic waitReady();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
endmodule

// >>> tb/oled_cmd_rmw_status_tb.sv
/*
 * self-checking bench for the command decoder slice.
 * assumes host_model drives the host pins; expectations come from the rules.
 */
`timescale 1ns/1ps
module oled_cmd_rmw_status_tb;
    import oled_cmd_pkg::*;
    typedef struct packed {
        logic cds;
        logic [7:0] d;
        logic [7:0] col;
        logic rmw;
        logic [7:0] desel;
    } row_t;
    localparam row_t ROWS [14] = '{
        '{1'b0, 8'hdb, 8'h00, 1'b0, 8'h35}, '{1'b0, 8'h00, 8'h00, 1'b0, 8'h00},
        '{1'b0, 8'hdb, 8'h00, 1'b0, 8'h00}, '{1'b0, 8'hff, 8'h00, 1'b0, 8'hff},
        '{1'b0, 8'h05, 8'h05, 1'b0, 8'hff}, '{1'b0, 8'h10, 8'h05, 1'b0, 8'hff},
        '{1'b1, 8'haa, 8'h06, 1'b0, 8'hff}, '{1'b0, 8'he0, 8'h06, 1'b1, 8'hff},
        '{1'b1, 8'h55, 8'h07, 1'b1, 8'hff}, '{1'b0, 8'he3, 8'h07, 1'b1, 8'hff},
        '{1'b0, 8'hee, 8'h06, 1'b0, 8'hff}, '{1'b0, 8'he3, 8'h06, 1'b0, 8'hff},
        '{1'b0, 8'hda, 8'h06, 1'b0, 8'hff}, '{1'b0, 8'h05, 8'h06, 1'b0, 8'hff}};
    logic clk;
    logic nrst;
    logic wrStrobe, rdStrobe, cmdDataSelect, serialMode, readValid, busy;
    logic displayOn, rmwActive;
    logic [7:0] dataIn, readData, rowDeselectLevel, comPadConfig, columnAddr;
    logic [2:0] pageAddr;
    int errTotal = 0;
    int checked = 0;
    oled_cmd_rmw_status uut (.clk(clk), .nrst(nrst), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
        .cmdDataSelect(cmdDataSelect), .serialMode(serialMode), .dataIn(dataIn),
        .readData(readData), .readValid(readValid), .busy(busy),
        .rowDeselectLevel(rowDeselectLevel), .comPadConfig(comPadConfig),
        .displayOn(displayOn), .rmwActive(rmwActive), .columnAddr(columnAddr),
        .pageAddr(pageAddr));
    host_model host (.clk(clk), .busy(busy), .readValid(readValid), .readData(readData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .cmdDataSelect(cmdDataSelect),
        .serialMode(serialMode), .dataIn(dataIn));
    ////////////////////////////////////////////////////////////////////////
    initial clk = 1'b0;
    always #20 clk = ~clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errTotal++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finalReport();
        $display("comparisons %0d mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #40000;
        errTotal++;
        finalReport();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        repeat (8) @(posedge clk);
        chk(rowDeselectLevel, DESELECT_RESET);
        chk(comPadConfig, 8'h12);
        nrst <= 1'b1;
        host.rd(1'b0);
        chk(host.lastRead, 8'hc0);
        host.wr(1'b0, 8'he0);
        host.waitReady();
        chk({7'h0, rmwActive}, 8'h00);
        $display("test reset and busy done");
        foreach (ROWS[i]) begin
            host.wr(ROWS[i].cds, ROWS[i].d);
            #1;
            chk(columnAddr, ROWS[i].col);
            chk({7'h0, rmwActive}, {7'h0, ROWS[i].rmw});
            chk(rowDeselectLevel, ROWS[i].desel);
        end
        chk(comPadConfig, 8'h05);
        $display("test command table done");
        host.wr(1'b0, 8'h05);
        host.wr(1'b0, 8'h10);
        host.rd(1'b1);
        chk(columnAddr, 8'h06);
        host.rd(1'b1);
        chk(host.lastRead, 8'haa);
        chk(columnAddr, 8'h07);
        host.wr(1'b0, 8'he0);
        host.rd(1'b1);
        chk(host.lastRead, 8'h55);
        chk(columnAddr, 8'h07);
        host.wr(1'b1, 8'h3c);
        #1;
        chk(columnAddr, 8'h08);
        host.wr(1'b0, 8'hee);
        #1;
        chk(columnAddr, 8'h07);
        $display("test readback and rmw done");
        host.rd(1'b0);
        chk(host.lastRead, 8'h40);
        host.wr(1'b0, 8'haf);
        #1;
        chk({7'h0, displayOn}, 8'h01);
        host.rd(1'b0);
        chk(host.lastRead, 8'h00);
        host.setSerial(1'b1);
        host.rd(1'b1);
        chk({7'h0, host.lastValid}, 8'h00);
        chk(columnAddr, 8'h07);
        host.setSerial(1'b0);
        host.wr(1'b0, 8'hb2);
        #1;
        chk({5'h0, pageAddr}, 8'h02);
        host.wr(1'b1, 8'h99);
        #1;
        chk(columnAddr, 8'h08);
        host.wr(1'b0, 8'h07);
        host.rd(1'b1);
        host.rd(1'b1);
        chk(host.lastRead, 8'h99);
        chk({7'h0, host.lastValid}, 8'h01);
        host.wr(1'b0, 8'h03);
        host.wr(1'b0, 8'h18);
        host.wr(1'b1, 8'h5a);
        #1;
        chk(columnAddr, 8'h00);
        $display("test status and serial done");
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(rowDeselectLevel, DESELECT_RESET);
        chk(comPadConfig, 8'h12);
        chk({7'h0, busy}, 8'h01);
        chk({5'h0, pageAddr}, 8'h00);
        nrst <= 1'b1;
        host.wr(1'b0, 8'hdb);
        host.waitReady();
        host.wr(1'b0, 8'h12);
        #1;
        chk(rowDeselectLevel, DESELECT_RESET);
        chk(columnAddr, 8'h20);
        $display("test reset in mid-run done");
        finalReport();
    end
endmodule
